// ### core/adapter_local_node_csr.sv
`timescale 1ns/1ps
`include "adapter_csr_defs.svh"

// Behaviour
// - each link problem sets an error flag in the status register; data and checksum errors share bit 7
// - error flags stay set until command bit 7 written one clears them
// - command bit 6 clears pending incoming peer interrupt and its flag
// - command bit 5 high drives outgoing peer interrupt; zero withdraws it
// - command bit 4 high blocks every interrupt onto the backplane
// - command bit 2 high blocks forwarding interrupts to the remote card
// - status bit 7 set on optical data error, cleared by clear-errors
// - status bit 6 set on any remote bus failure
// - status bit 5 set by incoming peer interrupt, cleared by bit 6
// - status bit 2 set on DMA over 16 ms or register access over 30 ms
// - status bit 1 high while sending peer interrupt, cleared by ack
// - status bit 0 shows link down; remote accesses then give errors
// - modifier register drives the bus only while DMA masters it
// - acknowledge of our interrupt returns the vector register
// - vector register is all ones after reset
// - vector register reachable only from the local bus side
// - offsets 08 to 0F are forwarded to the remote card
// - byte and word accesses accepted; longwords refused
module adapter_local_node_csr #(
  parameter int DMA_TIMEOUT_CYCLES =
    `DMA_TIMEOUT_MS * `NS_PER_MS / `CLK_PERIOD_NS,
  parameter int REG_TIMEOUT_CYCLES =
    `REG_TIMEOUT_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ioReq,
  input wire adapter_csr_pkg::io_req_t ioCmd,
  output adapter_csr_pkg::io_rsp_t ioRsp,
  output adapter_csr_pkg::remote_req_t remoteReq,
  input wire adapter_csr_pkg::remote_rsp_t remoteRsp,
  input wire adapter_csr_pkg::link_events_t linkEvents,
  input wire logic peerIntIn,
  input wire logic peerAckIn,
  input wire logic linkDownIn,
  input wire logic vmeIrqIn,
  output logic peerIntOut,
  output logic fwdIrqOut,
  input wire logic dmaDoneIrq,
  output logic vmeIrqOut,
  input wire logic iackReq,
  output logic iackAck,
  output logic [7:0] iackVector,
  input wire logic dmaActive,
  input wire logic dmaMastering,
  output logic [7:0] amOut,
  output logic amDrive
);
  import adapter_csr_pkg::*;

  localparam logic [`TMR_W-1:0] DMA_LAST =
    `TMR_W'(DMA_TIMEOUT_CYCLES - 1);
  // counter parks one past the limit so the timeout fires once
  localparam logic [`TMR_W-1:0] DMA_STOP =
    `TMR_W'(DMA_TIMEOUT_CYCLES);
  localparam logic [`TMR_W-1:0] REG_LAST =
    `TMR_W'(REG_TIMEOUT_CYCLES - 1);

  csr_state_t cur;
  csr_state_t next_s;
  logic [`SYNC_W-1:0] pins;
  logic peerRise;
  logic ackRise;
  logic idleReq;
  logic localReq;
  logic cmdWrite;
  logic [7:0] cmdByte;
  logic clearErrors;
  logic clearPeer;
  logic dmaExpire;
  logic regExpire;
  logic linkRefuse;

  // ----------------------------------------------------------------
  // byte lane helpers: even offset on the upper lane
  // ----------------------------------------------------------------
  function automatic logic byteHit(io_req_t r, logic [2:0] off);
    return (r.addr[2:1] == off[2:1]) &&
      (off[0] ? r.byteEn[0] : r.byteEn[1]);
  endfunction

  function automatic logic [7:0] wrByte(io_req_t r, logic [2:0] off);
    return off[0] ? r.wdata[7:0] : r.wdata[15:8];
  endfunction

  function automatic logic [7:0] rdByte(csr_state_t s, logic [2:0] off,
                                        logic down);
    logic [7:0] v;
    v = 8'h00;
    case (off)
      `OFF_COMMAND: begin
        v[`CMD_SEND_PEER] = s.sendPeer;
        v[`CMD_NO_VME_IRQ] = s.noVmeIrq;
        v[`CMD_NO_FWD_IRQ] = s.noFwdIrq;
      end
      `OFF_STATUS: begin
        v[`ST_DATA_ERROR] = s.dataError;
        v[`ST_BUS_ERROR] = s.busError;
        v[`ST_RX_PEER] = s.rxPeer;
        v[`ST_TIMEOUT] = s.timeout;
        v[`ST_SENDING] = s.sending;
        v[`ST_LINK_DOWN] = down;
      end
      `OFF_AM: v = s.am;
      `OFF_VECTOR: v = s.vector;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn({vmeIrqIn, linkDownIn, peerAckIn, peerIntIn}),
    .pinOut(pins)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign peerRise = pins[`PIN_PEER_IN] & ~cur.peerPrev;
  assign ackRise = pins[`PIN_PEER_ACK] & ~cur.ackPrev;
  assign idleReq = ioReq && (cur.state == BUS_IDLE);
  assign localReq = idleReq && !ioCmd.longword &&
    !ioCmd.addr[`REMOTE_SEL_BIT];
  assign cmdWrite = localReq && ioCmd.write &&
    byteHit(ioCmd, `OFF_COMMAND);
  assign cmdByte = wrByte(ioCmd, `OFF_COMMAND);
  assign clearErrors = cmdWrite && cmdByte[`CMD_CLEAR_ERRORS];
  assign clearPeer = cmdWrite && cmdByte[`CMD_CLEAR_PEER];
  assign dmaExpire = dmaActive && (cur.dmaCnt == DMA_LAST);
  assign regExpire = (cur.state == BUS_REMOTE) && !remoteRsp.ack &&
    (cur.remoteCnt == REG_LAST);
  assign linkRefuse = idleReq && !ioCmd.longword &&
    ioCmd.addr[`REMOTE_SEL_BIT] && pins[`PIN_LINK_DOWN];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = cur;
    next_s.rsp.ack = 1'b0;
    next_s.rsp.err = 1'b0;
    next_s.iackAck = 1'b0;
    next_s.peerPrev = pins[`PIN_PEER_IN];
    next_s.ackPrev = pins[`PIN_PEER_ACK];

    if (cmdWrite) begin
      next_s.sendPeer = cmdByte[`CMD_SEND_PEER];
      next_s.noVmeIrq = cmdByte[`CMD_NO_VME_IRQ];
      next_s.noFwdIrq = cmdByte[`CMD_NO_FWD_IRQ];
    end
    if (localReq && ioCmd.write && byteHit(ioCmd, `OFF_AM)) begin
      next_s.am = wrByte(ioCmd, `OFF_AM);
    end
    // only the local bus reaches the vector
    if (localReq && ioCmd.write && byteHit(ioCmd, `OFF_VECTOR)) begin
      next_s.vector = wrByte(ioCmd, `OFF_VECTOR);
    end

    // sticky flags: a set in the clearing cycle wins
    next_s.dataError = (cur.dataError & ~clearErrors) |
      linkEvents.dataError | linkEvents.checksumError;
    next_s.busError = (cur.busError & ~clearErrors) |
      linkEvents.busError;
    next_s.timeout = (cur.timeout & ~clearErrors) | dmaExpire |
      regExpire | linkRefuse;
    next_s.rxPeer = (cur.rxPeer & ~clearPeer) | peerRise;
    next_s.sending = (cur.sending & ~ackRise &
      ~(cmdWrite & ~cmdByte[`CMD_SEND_PEER])) |
      (cmdWrite & cmdByte[`CMD_SEND_PEER] & ~cur.sendPeer);

    if (!dmaActive) begin
      next_s.dmaCnt = '0;
    end else if (cur.dmaCnt != DMA_STOP) begin
      next_s.dmaCnt = cur.dmaCnt + 1'b1;
    end

    case (cur.state)
      BUS_IDLE: begin
        if (idleReq && ioCmd.longword) begin
          next_s.rsp.ack = 1'b1;
          next_s.rsp.err = 1'b1;
        end else if (linkRefuse) begin
          next_s.rsp.ack = 1'b1;
          next_s.rsp.err = 1'b1;
        end else if (idleReq && ioCmd.addr[`REMOTE_SEL_BIT]) begin
          next_s.state = BUS_REMOTE;
          next_s.remoteCnt = '0;
          next_s.remote.req = 1'b1;
          next_s.remote.write = ioCmd.write;
          next_s.remote.wordAddr = ioCmd.addr[2:1];
          next_s.remote.byteEn = ioCmd.byteEn;
          next_s.remote.wdata = ioCmd.wdata;
        end else if (localReq) begin
          next_s.rsp.ack = 1'b1;
          next_s.rsp.rdata = 16'h0000;
          if (!ioCmd.write) begin
            if (ioCmd.byteEn[1]) begin
              next_s.rsp.rdata[15:8] = rdByte(cur,
                {ioCmd.addr[2:1], 1'b0}, pins[`PIN_LINK_DOWN]);
            end
            if (ioCmd.byteEn[0]) begin
              next_s.rsp.rdata[7:0] = rdByte(cur,
                {ioCmd.addr[2:1], 1'b1}, pins[`PIN_LINK_DOWN]);
            end
          end
        end
      end
      BUS_REMOTE: begin
        next_s.remoteCnt = cur.remoteCnt + 1'b1;
        if (remoteRsp.ack) begin
          next_s.rsp.ack = 1'b1;
          next_s.rsp.rdata = remoteRsp.rdata;
          next_s.remote.req = 1'b0;
          next_s.state = BUS_IDLE;
        end else if (regExpire) begin
          next_s.rsp.ack = 1'b1;
          next_s.rsp.err = 1'b1;
          next_s.remote.req = 1'b0;
          next_s.state = BUS_IDLE;
        end
      end
      default: begin
        next_s.state = BUS_IDLE;
        next_s.remote.req = 1'b0;
      end
    endcase

    next_s.vmeIrq = (cur.rxPeer | dmaDoneIrq) & ~cur.noVmeIrq;
    next_s.fwdIrq = pins[`PIN_VME_IRQ] & ~cur.noFwdIrq;
    if (iackReq && cur.vmeIrq) begin
      next_s.iackAck = 1'b1;
      next_s.iackVector = cur.vector;
    end
    next_s.amDrive = dmaMastering;
    next_s.amOut = dmaMastering ? cur.am : 8'h00;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
      cur.state <= BUS_IDLE;
      cur.am <= `AM_RESET;
      cur.vector <= `VECTOR_RESET;
    end else begin
      cur <= next_s;
    end
  end

  assign ioRsp = cur.rsp;
  assign remoteReq = cur.remote;
  assign peerIntOut = cur.sendPeer;
  assign fwdIrqOut = cur.fwdIrq;
  assign vmeIrqOut = cur.vmeIrq;
  assign iackAck = cur.iackAck;
  assign iackVector = cur.iackVector;
  assign amOut = cur.amOut;
  assign amDrive = cur.amDrive;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_errors_cleared: assert property (
    clearErrors && !linkEvents.dataError && !linkEvents.checksumError
    && !linkEvents.busError |=> !cur.dataError && !cur.busError)
    else $error("error flags not cleared");
  a_error_sticky: assert property (
    cur.dataError && !clearErrors |=> cur.dataError)
    else $error("data error flag lost");
  a_error_set: assert property (
    linkEvents.checksumError |=> ##1 cur.dataError || $past(clearErrors))
    else $error("checksum error not latched");
  a_bus_error: assert property (
    linkEvents.busError |=> cur.busError)
    else $error("bus error not latched");
  a_peer_clear: assert property (
    clearPeer && !peerRise |=> !cur.rxPeer
    ##1 (!vmeIrqOut || $past(dmaDoneIrq)))
    else $error("peer interrupt not cleared");
  a_peer_set: assert property (
    peerRise |=> cur.rxPeer)
    else $error("incoming peer not flagged");
  a_peer_send: assert property (
    cmdWrite && cmdByte[`CMD_SEND_PEER] && !cur.sendPeer
    |=> peerIntOut && cur.sending)
    else $error("outgoing peer not driven");
  a_sent_ack: assert property (
    ackRise && !cmdWrite |=> !cur.sending)
    else $error("sending flag not cleared by ack");
  a_vme_block: assert property (
    cur.noVmeIrq |=> !vmeIrqOut)
    else $error("backplane interrupt while blocked");
  a_fwd_block: assert property (
    cur.noFwdIrq |=> !fwdIrqOut)
    else $error("forwarded interrupt while blocked");
  a_dma_timeout: assert property (
    dmaExpire |=> cur.timeout)
    else $error("dma timeout not flagged");
  a_link_refuse: assert property (
    linkRefuse |=> ioRsp.ack && ioRsp.err && !remoteReq.req
    && cur.timeout)
    else $error("access while link down not refused");
  a_am_window: assert property (
    !dmaMastering |=> !amDrive && amOut == 8'h00)
    else $error("modifier driven outside dma");
  a_iack_vector: assert property (
    iackReq && vmeIrqOut |=> iackAck && iackVector == $past(cur.vector))
    else $error("wrong vector on acknowledge");
  a_remote_fwd: assert property (
    idleReq && !ioCmd.longword && ioCmd.addr[`REMOTE_SEL_BIT]
    && !pins[`PIN_LINK_DOWN] |=> remoteReq.req && !ioRsp.ack)
    else $error("remote offset not forwarded");
  a_longword_refused: assert property (
    idleReq && ioCmd.longword |=> ioRsp.ack && ioRsp.err
    && $stable(cur.vector) && !remoteReq.req)
    else $error("longword access not refused");
  a_oneshot_read: assert property (
    localReq && !ioCmd.write && ioCmd.addr[2:1] == 2'b00
    |=> ioRsp.rdata[7:6] == 2'b00)
    else $error("one-shot command bits read back");

  c_remote_done: cover property (
    cur.state == BUS_REMOTE && remoteRsp.ack);
  c_remote_timeout: cover property (regExpire);
  c_iack: cover property (iackAck);
  c_clear_race: cover property (clearErrors && linkEvents.dataError);

endmodule

// ### core/adapter_csr_defs.svh
`ifndef ADAPTER_CSR_DEFS_SVH
`define ADAPTER_CSR_DEFS_SVH

// ----------------------------------------------------------------
// local node offsets within the io window
// ----------------------------------------------------------------
`define OFF_LOOPBACK 3'h0
`define OFF_COMMAND 3'h1
`define OFF_STATUS 3'h3
`define OFF_AM 3'h4
`define OFF_VECTOR 3'h7
`define REMOTE_SEL_BIT 3

// ----------------------------------------------------------------
// command bits
// ----------------------------------------------------------------
`define CMD_CLEAR_ERRORS 7
`define CMD_CLEAR_PEER 6
`define CMD_SEND_PEER 5
`define CMD_NO_VME_IRQ 4
`define CMD_NO_FWD_IRQ 2

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define ST_DATA_ERROR 7
`define ST_BUS_ERROR 6
`define ST_RX_PEER 5
`define ST_TIMEOUT 2
`define ST_SENDING 1
`define ST_LINK_DOWN 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VECTOR_RESET 8'hFF
`define AM_RESET 8'h00

// ----------------------------------------------------------------
// synchronised pins
// ----------------------------------------------------------------
`define SYNC_W 4
`define PIN_PEER_IN 0
`define PIN_PEER_ACK 1
`define PIN_LINK_DOWN 2
`define PIN_VME_IRQ 3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define DMA_TIMEOUT_MS 16
`define REG_TIMEOUT_MS 30
`define NS_PER_MS 1000000
`define TMR_W 20

`endif

// ### core/adapter_csr_pkg.sv
`include "adapter_csr_defs.svh"

package adapter_csr_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_REMOTE = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic write;
    logic longword;
    logic [3:0] addr;
    logic [1:0] byteEn;
    logic [15:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } io_rsp_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [1:0] wordAddr;
    logic [1:0] byteEn;
    logic [15:0] wdata;
  } remote_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } remote_rsp_t;

  typedef struct packed {
    logic dataError;
    logic checksumError;
    logic busError;
  } link_events_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    logic [`SYNC_W-1:0] q;
  } sync_state_t;

  typedef struct packed {
    bus_state_t state;
    logic sendPeer;
    logic noVmeIrq;
    logic noFwdIrq;
    logic dataError;
    logic busError;
    logic rxPeer;
    logic timeout;
    logic sending;
    logic [7:0] am;
    logic [7:0] vector;
    logic peerPrev;
    logic ackPrev;
    logic [`TMR_W-1:0] remoteCnt;
    logic [`TMR_W-1:0] dmaCnt;
    remote_req_t remote;
    io_rsp_t rsp;
    logic iackAck;
    logic [7:0] iackVector;
    logic vmeIrq;
    logic fwdIrq;
    logic [7:0] amOut;
    logic amDrive;
  } csr_state_t;

endpackage

// ### core/pin_sync.sv
`timescale 1ns/1ps
`include "adapter_csr_defs.svh"

module pin_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`SYNC_W-1:0] pinIn,
  output logic [`SYNC_W-1:0] pinOut
);
  import adapter_csr_pkg::*;

  sync_state_t cur;
  sync_state_t next_s;
  wire logic [`SYNC_W-1:0] next_q;

  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `SYNC_W; i++) begin : g_bit
    assign next_q[i] = (cur.s2[i] == cur.s3[i]) ? cur.s3[i] : cur.q[i];
  end

  always_comb begin
    next_s = cur;
    next_s.s1 = pinIn;
    next_s.s2 = cur.s1;
    next_s.s3 = cur.s2;
    next_s.q = next_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_s;
    end
  end

  assign pinOut = cur.q;

endmodule

// ### verif/remote_card_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// remote card: word store behind the cable, answer after dly
// ------------------------------------------------------------
module remote_card_model (
  input wire logic ref_clk,
  input wire adapter_csr_pkg::remote_req_t remoteReq,
  input wire logic [7:0] dly,
  output adapter_csr_pkg::remote_rsp_t remoteRsp
);
  import adapter_csr_pkg::*;
  logic [15:0] mem [4];
  logic [7:0] cnt;

  initial begin
    remoteRsp = '0;
    cnt = '0;
    mem = '{default: 16'h0000};
  end

  always @(posedge ref_clk) begin
    remoteRsp.ack <= 1'b0;
    // data lines toggle outside the answer so stale data never matches
    remoteRsp.rdata <= ~remoteRsp.rdata;
    if (!remoteReq.req || remoteRsp.ack) begin
      cnt <= '0;
    end else if (cnt == dly) begin
      remoteRsp.ack <= 1'b1;
      cnt <= '0;
      if (remoteReq.write) begin
        mem[remoteReq.wordAddr] <= remoteReq.wdata;
      end
      remoteRsp.rdata <= mem[remoteReq.wordAddr];
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ### verif/test_adapter_local_node_csr.sv
`timescale 1ns/1ps

module test_adapter_local_node_csr;
  import adapter_csr_pkg::*;
  logic ref_clk, reset_n, ioReq, peerIntIn, peerAckIn, linkDownIn;
  logic vmeIrqIn, dmaDoneIrq, iackReq, dmaActive, dmaMastering;
  logic peerIntOut, fwdIrqOut, vmeIrqOut, iackAck, amDrive, lastErr;
  logic [7:0] iackVector, amOut, dly, rb;
  io_req_t ioCmd;
  io_rsp_t ioRsp;
  remote_req_t remoteReq;
  remote_rsp_t remoteRsp;
  link_events_t linkEvents;
  int miscompares, testsRun, cyc;

  adapter_local_node_csr #(
    .DMA_TIMEOUT_CYCLES(20),
    .REG_TIMEOUT_CYCLES(30)
  ) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .ioReq(ioReq),
    .ioCmd(ioCmd), .ioRsp(ioRsp), .remoteReq(remoteReq),
    .remoteRsp(remoteRsp), .linkEvents(linkEvents),
    .peerIntIn(peerIntIn), .peerAckIn(peerAckIn),
    .linkDownIn(linkDownIn), .vmeIrqIn(vmeIrqIn),
    .peerIntOut(peerIntOut), .fwdIrqOut(fwdIrqOut),
    .dmaDoneIrq(dmaDoneIrq), .vmeIrqOut(vmeIrqOut),
    .iackReq(iackReq), .iackAck(iackAck), .iackVector(iackVector),
    .dmaActive(dmaActive), .dmaMastering(dmaMastering),
    .amOut(amOut), .amDrive(amDrive)
  );

  remote_card_model u_remote (
    .ref_clk(ref_clk), .remoteReq(remoteReq), .dly(dly),
    .remoteRsp(remoteRsp)
  );

  always #20 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // byte access: odd offset on the low lane, even on the high lane
  task automatic io(input logic w, input logic lw, input logic [3:0] a,
                    input logic [7:0] d);
    int n;
    ioCmd <= '{write: w, longword: lw, addr: a,
               byteEn: a[0] ? 2'b01 : 2'b10, wdata: {d, d}};
    ioReq <= 1'b1;
    tick(1);
    ioReq <= 1'b0;
    n = 0;
    while (ioRsp.ack !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("answer", 16'h0001, 16'(n < 100));
    rb = a[0] ? ioRsp.rdata[7:0] : ioRsp.rdata[15:8];
    lastErr = ioRsp.err;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    io(1'b1, 1'b0, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [3:0] a,
                       input logic [7:0] e);
    io(1'b0, 1'b0, a, 8'h00);
    chk(nm, 16'(e), 16'(rb));
  endtask

  task automatic ev(input link_events_t e);
    linkEvents <= e;
    tick(1);
    linkEvents <= '0;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {ioReq, peerIntIn, peerAckIn, linkDownIn, vmeIrqIn} = '0;
    {dmaDoneIrq, iackReq, dmaActive, dmaMastering} = '0;
    ref_clk = 1'b0;
    reset_n = 1'b0;
    ioCmd = '0;
    linkEvents = '0;
    dly = 8'h00;
    tick(6);
    reset_n <= 1'b1;
    tick(1);
    rdchk("vector", 4'h7, 8'hFF);
    rdchk("am", 4'h4, 8'h00);
    rdchk("status", 4'h3, 8'h00);
    rdchk("command", 4'h1, 8'h00);
    rdchk("unmapped", 4'h5, 8'h00);
    $display("test reset done");
    wr(4'h4, 8'h3D);
    rdchk("am", 4'h4, 8'h3D);
    wr(4'h7, 8'h5A);
    rdchk("vector", 4'h7, 8'h5A);
    chk("amDrive idle", 16'h0000, 16'(amDrive));
    dmaMastering <= 1'b1;
    tick(2);
    chk("amDrive", 16'h0001, 16'(amDrive));
    chk("amOut", 16'h003D, 16'(amOut));
    dmaMastering <= 1'b0;
    tick(2);
    chk("amOut off", 16'h0000, 16'(amOut));
    $display("test registers done");
    wr(4'h1, 8'h20);
    chk("peerIntOut", 16'h0001, 16'(peerIntOut));
    rdchk("status", 4'h3, 8'h02);
    rdchk("command", 4'h1, 8'h20);
    peerAckIn <= 1'b1;
    tick(5);
    rdchk("status", 4'h3, 8'h00);
    peerAckIn <= 1'b0;
    wr(4'h1, 8'h00);
    chk("peerIntOut", 16'h0000, 16'(peerIntOut));
    $display("test outgoing done");
    peerIntIn <= 1'b1;
    tick(5);
    rdchk("status", 4'h3, 8'h20);
    chk("vmeIrqOut", 16'h0001, 16'(vmeIrqOut));
    iackReq <= 1'b1;
    tick(1);
    iackReq <= 1'b0;
    tick(1);
    chk("iackAck", 16'h0001, 16'(iackAck));
    chk("iackVector", 16'h005A, 16'(iackVector));
    wr(4'h1, 8'h10);
    tick(2);
    chk("vmeIrqOut", 16'h0000, 16'(vmeIrqOut));
    wr(4'h1, 8'h50);
    rdchk("status", 4'h3, 8'h00);
    rdchk("command", 4'h1, 8'h10);
    peerIntIn <= 1'b0;
    wr(4'h1, 8'h00);
    dmaDoneIrq <= 1'b1;
    tick(2);
    chk("vmeIrqOut", 16'h0001, 16'(vmeIrqOut));
    dmaDoneIrq <= 1'b0;
    $display("test incoming done");
    for (int i = 0; i < 3; i++) begin
      ev(link_events_t'(3'b001 << i));
      rdchk("status", 4'h3, i == 0 ? 8'h40 : 8'h80);
      ev(link_events_t'(3'b001 << i));
      rdchk("status", 4'h3, i == 0 ? 8'h40 : 8'h80);
      wr(4'h1, 8'h80);
      rdchk("status", 4'h3, 8'h00);
    end
    $display("test errors done");
    vmeIrqIn <= 1'b1;
    tick(6);
    chk("fwdIrqOut", 16'h0001, 16'(fwdIrqOut));
    wr(4'h1, 8'h04);
    tick(2);
    chk("fwdIrqOut", 16'h0000, 16'(fwdIrqOut));
    wr(4'h1, 8'h00);
    tick(5);
    chk("fwdIrqOut", 16'h0001, 16'(fwdIrqOut));
    vmeIrqIn <= 1'b0;
    $display("test forward done");
    wr(4'hA, 8'h77);
    rdchk("remote", 4'hA, 8'h77);
    dly <= 8'h05;
    wr(4'hD, 8'h99);
    rdchk("remote", 4'hD, 8'h99);
    chk("err", 16'h0000, 16'(lastErr));
    rdchk("local", 4'h4, 8'h3D);
    dly <= 8'h28;
    io(1'b0, 1'b0, 4'h8, 8'h00);
    rdchk("status", 4'h3, 8'h04);
    wr(4'h1, 8'h80);
    dly <= 8'h00;
    $display("test remote done");
    linkDownIn <= 1'b1;
    tick(5);
    rdchk("status", 4'h3, 8'h01);
    io(1'b0, 1'b0, 4'h8, 8'h00);
    chk("err", 16'h0001, 16'(lastErr));
    rdchk("status", 4'h3, 8'h05);
    linkDownIn <= 1'b0;
    tick(5);
    wr(4'h1, 8'h80);
    rdchk("status", 4'h3, 8'h00);
    $display("test link done");
    dmaActive <= 1'b1;
    tick(10);
    rdchk("status", 4'h3, 8'h00);
    tick(12);
    rdchk("status", 4'h3, 8'h04);
    dmaActive <= 1'b0;
    wr(4'h1, 8'h80);
    io(1'b1, 1'b1, 4'h7, 8'h11);
    chk("err", 16'h0001, 16'(lastErr));
    rdchk("vector", 4'h7, 8'h5A);
    $display("test dma done");
    end_sim();
  end
endmodule
